/* dot_map.svh */
// offsets, field positions, timing values and counts for drive-order trigger logic
`ifndef DOT_MAP_SVH
`define DOT_MAP_SVH
`define DOT_NUM_IN 5
`define DOT_NUM_CB 5
`define DOT_NUM_ORDERS 8
`define DOT_SEL_W 6
`define DOT_SEL_NONE 6'h00
`define DOT_SRC_DI_BASE 6'h01
`define DOT_SRC_CB_BASE 6'h15
`define DOT_SRC_LAST 6'h28
`define DOT_IDX_RISE 2'h0
`define DOT_IDX_FALL 2'h1
`define DOT_IDX_LEVEL 2'h2
`define DOT_IDX_INV 2'h3
`define DOT_TICK_PERIOD_US 1000
`define DOT_CLK_MHZ 20
`define DOT_TICK_CYCLES ((`DOT_TICK_PERIOD_US) * (`DOT_CLK_MHZ))
`endif

/* dot_pkg.sv */
// types for drive-order trigger logic
package dot_pkg;
   typedef enum logic [1:0] {
      dot_kind_rise_t_v = 2'h0,
      dot_kind_fall_t_v = 2'h1,
      dot_kind_level_t_v = 2'h2,
      dot_kind_inv_t_v = 2'h3
   } dot_kind_t;
endpackage : dot_pkg

/* dot_order_latch.sv */
// held state of drive orders, one bit per order, registered output
`include "dot_map.svh"
module dot_order_latch #(
   parameter int NUM_ORDERS = `DOT_NUM_ORDERS
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // set and release per order
   input wire logic [NUM_ORDERS-1:0] set_req,
   input wire logic [NUM_ORDERS-1:0] release_req,
   // held orders
   output logic [NUM_ORDERS-1:0] held
);
   logic [NUM_ORDERS-1:0] next_held;

   // set beats release so a trigger in the release cycle is not lost
   always_comb begin
      next_held = (held & ~release_req) | set_req;
   end

   // register only
   always_ff @(posedge clk) begin
      if (reset) begin
         held <= '0;
      end else begin
         held <= next_held;
      end
   end
endmodule : dot_order_latch

/* dot_trigger.sv */
// drive-order trigger logic: edge and level outputs of inputs and control bits
`include "dot_map.svh"

// How it works
// [R01] each drive order has a configured selector naming one function-block output
// [R02] an order fed from a level output is active only while that output is high
// [R03] edge outputs are high for exactly one clock per edge
// [R04] orders fed from an edge output are latched past the pulse
// [R05] each input and control bit has rising and falling edge outputs
// [R06] each input and control bit has a level output following its latest tick sample
// [R07] each digital input also has an inverted level output
// [R08] inputs sampled once per evaluation tick; edges compare with prior sample
module dot_trigger #(
   parameter int NUM_ORDERS = `DOT_NUM_ORDERS,
   parameter int TICK_CYCLES = `DOT_TICK_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // raw inputs
   input wire logic [`DOT_NUM_IN-1:0] digital_input,
   input wire logic [`DOT_NUM_CB-1:0] control_bit,
   // configuration: selected source per order, flat
   input wire logic [NUM_ORDERS*`DOT_SEL_W-1:0] order_select,
   // release of held orders, one per order
   input wire logic [NUM_ORDERS-1:0] order_release,
   // function-block outputs
   output logic [`DOT_NUM_IN-1:0] di_rise,
   output logic [`DOT_NUM_IN-1:0] di_fall,
   output logic [`DOT_NUM_IN-1:0] di_level,
   output logic [`DOT_NUM_IN-1:0] di_inverted,
   output logic [`DOT_NUM_CB-1:0] cb_rise,
   output logic [`DOT_NUM_CB-1:0] cb_fall,
   output logic [`DOT_NUM_CB-1:0] cb_level,
   // evaluation tick and drive orders
   output logic eval_tick,
   output logic [NUM_ORDERS-1:0] drive_order
);
   // inputs and control bits share one source vector, inputs in the low bits
   localparam int NSRC = `DOT_NUM_IN + `DOT_NUM_CB;

   // ------------------------------------------------------------
   // evaluation tick
   // ------------------------------------------------------------
   logic [31:0] tick_cnt;
   logic [31:0] next_tick_cnt;
   logic next_eval_tick;

   // free-running divider; one pulse per evaluation cycle
   always_comb begin
      next_eval_tick = (tick_cnt == 32'(TICK_CYCLES - 1));
      next_tick_cnt = next_eval_tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         tick_cnt <= 32'h0000_0000;
         eval_tick <= 1'b0;
      end else begin
         tick_cnt <= next_tick_cnt;
         eval_tick <= next_eval_tick;
      end
   end

   // ------------------------------------------------------------
   // sampling and edge detection
   // ------------------------------------------------------------
   logic [NSRC-1:0] cur;
   logic [NSRC-1:0] prev;
   logic [NSRC-1:0] rise;
   logic [NSRC-1:0] fall;
   logic [NSRC-1:0] next_cur;
   logic [NSRC-1:0] next_prev;
   logic [NSRC-1:0] next_rise;
   logic [NSRC-1:0] next_fall;

   // sample on tick only; pulses fall back to zero on the very next clock,
   // so each edge output is high for exactly one clock after the tick
   always_comb begin
      next_cur = cur;
      next_prev = prev;
      next_rise = '0; // [R03]
      next_fall = '0; // [R03]
      if (eval_tick) begin
         next_prev = cur; // [R08]
         next_cur = {control_bit, digital_input}; // [R08]
         next_rise = {control_bit, digital_input} & ~cur; // [R03] [R05]
         next_fall = ~{control_bit, digital_input} & cur; // [R03] [R05]
      end
   end

   // reset assumes all inputs low, so an input high at start gives a rise
   always_ff @(posedge clk) begin
      if (reset) begin
         cur <= '0;
         prev <= '0;
         rise <= '0;
         fall <= '0;
      end else begin
         cur <= next_cur;
         prev <= next_prev;
         rise <= next_rise;
         fall <= next_fall;
      end
   end

   // outputs split back into inputs and control bits
   assign di_rise = rise[`DOT_NUM_IN-1:0]; // [R05]
   assign di_fall = fall[`DOT_NUM_IN-1:0]; // [R05]
   assign di_level = cur[`DOT_NUM_IN-1:0]; // [R06]
   assign di_inverted = ~cur[`DOT_NUM_IN-1:0]; // [R07]
   assign cb_rise = rise[NSRC-1:`DOT_NUM_IN]; // [R05]
   assign cb_fall = fall[NSRC-1:`DOT_NUM_IN]; // [R05]
   assign cb_level = cur[NSRC-1:`DOT_NUM_IN]; // [R06]

   // ------------------------------------------------------------
   // source selection per order
   // ------------------------------------------------------------
   // selector code: 0 none; then per input 4 codes, per control bit 4
   // code 1 + 4 * source + kind, with kind 0 rise, 1 fall, 2 level, 3 inverted
   // sources 0..4 are the digital inputs, 5..9 the control bits
   // codes above the last valid one read as none, so a stray value
   // in the configuration can never start the drive
   function automatic logic src_value(input logic [`DOT_SEL_W-1:0] sel,
                                      input logic [NSRC-1:0] r,
                                      input logic [NSRC-1:0] f,
                                      input logic [NSRC-1:0] l);
      logic [`DOT_SEL_W-1:0] off;
      logic [3:0] idx;
      logic [1:0] kind;
      off = sel - `DOT_SRC_DI_BASE;
      idx = off[5:2];
      kind = off[1:0];
      src_value = 1'b0;
      if (sel != `DOT_SEL_NONE && sel <= `DOT_SRC_LAST && int'(idx) < NSRC) begin
         unique case (dot_pkg::dot_kind_t'(kind))
            dot_pkg::dot_kind_rise_t_v: src_value = r[idx];
            dot_pkg::dot_kind_fall_t_v: src_value = f[idx];
            dot_pkg::dot_kind_level_t_v: src_value = l[idx];
            // inverted level exists for digital inputs only
            dot_pkg::dot_kind_inv_t_v: src_value = (int'(idx) < `DOT_NUM_IN) ? ~l[idx] : 1'b0;
         endcase
      end
   endfunction : src_value

   // rise and fall kinds have bit 1 of the offset clear; only those latch
   function automatic logic is_edge(input logic [`DOT_SEL_W-1:0] sel);
      logic [`DOT_SEL_W-1:0] off;
      off = sel - `DOT_SRC_DI_BASE;
      is_edge = (sel != `DOT_SEL_NONE) && (sel <= `DOT_SRC_LAST) && !off[1];
   endfunction : is_edge

   logic [NUM_ORDERS-1:0] src_now;
   logic [NUM_ORDERS-1:0] edge_set;
   logic [NUM_ORDERS-1:0] edge_kind;
   logic [NUM_ORDERS-1:0] held;

   genvar g;
   generate
      for (g = 0; g < NUM_ORDERS; g++) begin : g_order
         logic [`DOT_SEL_W-1:0] sel;
         assign sel = order_select[g*`DOT_SEL_W +: `DOT_SEL_W]; // [R01]
         assign src_now[g] = src_value(sel, rise, fall, cur); // [R01]
         assign edge_kind[g] = is_edge(sel);
         assign edge_set[g] = edge_kind[g] & src_now[g]; // [R04]
      end
   endgenerate

   // ------------------------------------------------------------
   // order latch
   // ------------------------------------------------------------
   // latched orders for edge sources; release by the drive controller;
   // a level-sourced order keeps its latch cleared, so a later change of
   // selector to an edge kind starts from an empty latch
   dot_order_latch #(
      .NUM_ORDERS(NUM_ORDERS)
   ) u_latch (
      .clk(clk),
      .reset(reset),
      .set_req(edge_set),
      .release_req(order_release | ~edge_kind),
      .held(held)
   );

   // ------------------------------------------------------------
   // order output
   // ------------------------------------------------------------
   // level sources act only while high; edge sources via the latch;
   // the live pulse is ored in so the order shows in the pulse cycle
   // itself, one clock before the latch has caught it
   always_comb begin
      drive_order = '0;
      for (int i = 0; i < NUM_ORDERS; i++) begin
         if (edge_kind[i]) begin
            drive_order[i] = held[i] | edge_set[i]; // [R04]
         end else begin
            drive_order[i] = src_now[i]; // [R02]
         end
      end
   end
endmodule : dot_trigger

/* dot_trigger_checker.sv */
// assertion checker for the drive-order trigger block
module dot_trigger_checker #(parameter int NUM_ORDERS = 8, parameter int TICK_CYCLES = 4) (
   // clock, reset and inputs
   input wire logic clk, reset,
   input wire logic [4:0] digital_input, control_bit,
   input wire logic [NUM_ORDERS*6-1:0] order_select,
   input wire logic [NUM_ORDERS-1:0] order_release,
   // function-block outputs and orders
   input wire logic [4:0] di_rise, di_fall, di_level, di_inverted, cb_rise, cb_fall, cb_level,
   input wire logic eval_tick,
   input wire logic [NUM_ORDERS-1:0] drive_order
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic [63:0] fbv;
   logic [31:0] gap;
   // clocks since the last tick or reset; the tick must come at the count
   always_ff @(posedge clk) begin
      if (reset) gap <= 32'h0;
      else gap <= eval_tick ? 32'h1 : gap + 32'h1;
   end
   // outputs by selector code; code 0 and codes past the table read low
   always_comb begin
      fbv = '0;
      for (int i = 0; i < 5; i++) begin
         fbv[1+4*i+:4] = {di_inverted[i], di_level[i], di_fall[i], di_rise[i]};
         fbv[21+4*i+:4] = {1'b0, cb_level[i], cb_fall[i], cb_rise[i]};
      end
   end
   property p_gap; eval_tick == (gap == 32'(TICK_CYCLES)); endproperty
   a_gap: assert property (p_gap) else $error("tick spacing wrong");
   property p_lvl; eval_tick |=> di_level == $past(digital_input) && cb_level == $past(control_bit); endproperty
   a_lvl: assert property (p_lvl) else $error("level sample wrong");
   property p_inv; di_inverted == ~di_level; endproperty
   a_inv: assert property (p_inv) else $error("inverted level wrong");
   property p_die; eval_tick |=> di_rise == (di_level & ~$past(di_level)) && di_fall == (~di_level & $past(di_level)); endproperty
   a_die: assert property (p_die) else $error("input edge wrong");
   property p_cbe; eval_tick |=> cb_rise == (cb_level & ~$past(cb_level)) && cb_fall == (~cb_level & $past(cb_level)); endproperty
   a_cbe: assert property (p_cbe) else $error("control edge wrong");
   property p_one; !$past(eval_tick) |-> {di_rise, di_fall, cb_rise, cb_fall} == 20'h0; endproperty
   a_one: assert property (p_one) else $error("edge pulse too long");
   // per-order source relations; edge kinds latch, level kinds follow
   for (genvar g = 0; g < NUM_ORDERS; g++) begin : g_ord
      logic [5:0] s, k;
      logic lv;
      assign s = order_select[g*6+:6];
      assign k = s - 6'h01;
      assign lv = s == 6'h00 || s > 6'h28 || k[1];
      property p_fol; lv |-> drive_order[g] == fbv[s]; endproperty
      a_fol: assert property (p_fol) else $error("level order wrong");
      property p_set; !lv && fbv[s] |-> drive_order[g]; endproperty
      a_set: assert property (p_set) else $error("edge order not set");
      property p_hold; !lv && $past(drive_order[g]) && !$past(order_release[g]) && $stable(order_select) |-> drive_order[g]; endproperty
      a_hold: assert property (p_hold) else $error("latched order lost");
   end
endmodule : dot_trigger_checker
bind dot_trigger dot_trigger_checker #(.NUM_ORDERS(NUM_ORDERS), .TICK_CYCLES(TICK_CYCLES)) i_chk (.*);

/* dot_drive_model.sv */
// door drive model: accepts held orders by releasing them
module dot_drive_model #(parameter int NUM_ORDERS = 8) (
   // clock
   input wire logic clk,
   // orders and acceptance wish from the bench
   input wire logic [NUM_ORDERS-1:0] drive_order,
   input wire logic [NUM_ORDERS-1:0] accept,
   // release back to the trigger logic
   output logic [NUM_ORDERS-1:0] order_release = '0
);
   // one clock late, and only orders that drive_order shows active
   always @(posedge clk) order_release <= accept & drive_order;
endmodule : dot_drive_model

/* test_drive_order_trigger_logic.sv */
// self-checking bench for the drive-order trigger block
module test_drive_order_trigger_logic;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [4:0] di = '0, cb = '0, pdi = '0, pcb = '0, dr, df, dl, dv, cr, cf, cl;
   logic [47:0] sel = 48'h4;
   logic [7:0] acc = '0, rel, dord, lat = '0, exp;
   logic tick;
   logic [31:0] rng = 32'h3e1a;
   int miscompares = 0;
   int samples_checked = 0;
   always #25 clk = ~clk;
   dot_trigger #(.NUM_ORDERS(8), .TICK_CYCLES(4)) i_dut (.clk(clk), .reset(reset),
      .digital_input(di), .control_bit(cb), .order_select(sel), .order_release(rel),
      .di_rise(dr), .di_fall(df), .di_level(dl), .di_inverted(dv), .cb_rise(cr),
      .cb_fall(cf), .cb_level(cl), .eval_tick(tick), .drive_order(dord));
   dot_drive_model #(.NUM_ORDERS(8)) i_drive (.clk(clk), .drive_order(dord), .accept(acc),
      .order_release(rel));
   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] a;
      a = x ^ (x << 13);
      a = a ^ (a >> 17);
      return a ^ (a << 5);
   endfunction : xs
   // expected value of one selectable output for the latest sample
   function automatic logic src(input logic [5:0] c);
      logic [5:0] k;
      logic [3:0] i;
      logic n, o;
      k = c - 6'h01;
      i = k[5:2];
      n = i < 4'h5 ? di[i] : cb[i-4'h5];
      o = i < 4'h5 ? pdi[i] : pcb[i-4'h5];
      if (c == 6'h00 || c > 6'h28) return 1'b0;
      case (k[1:0])
         2'h0: return n & ~o;
         2'h1: return ~n & o;
         2'h2: return n;
         default: return i < 4'h5 ? ~n : 1'b0;
      endcase
   endfunction : src
   task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] want);
      samples_checked++;
      if (seen !== want) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, want, seen);
      end
   endtask : chk
   task automatic end_sim;
      $display("compares %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   // main sequence: one random sample per tick, corner values first
   initial begin
      logic [5:0] c;
      logic e;
      repeat (5) @(negedge clk);
      reset = 1'b0;
      chk("reset_orders", dord, 8'h01);
      for (int n = 0; n < 300; n++) begin
         for (int w = 0; w < 8 && tick !== 1'b1; w++) @(negedge clk);
         pdi = di;
         pcb = cb;
         rng = xs(rng);
         di = n < 2 ? {5{n[0]}} : rng[4:0];
         cb = n < 2 ? {5{n[0]}} : rng[9:5];
         @(negedge clk);
         for (int g = 0; g < 8; g++) begin
            c = sel[g*6+:6];
            e = c != 6'h00 && c <= 6'h28 && ((c - 6'h01) & 6'h02) == 6'h00;
            exp[g] = e ? lat[g] | src(c) : src(c);
            lat[g] = e & exp[g];
         end
         chk("di_level", dl, di);
         chk("di_inverted", dv, di ^ 5'h1f);
         chk("di_edges", {dr, df}, {di & ~pdi, ~di & pdi});
         chk("cb_level", cl, cb);
         chk("cb_edges", {cr, cf}, {cb & ~pcb, ~cb & pcb});
         chk("drive_order", dord, exp);
         acc = rng[17:10];
         lat = lat & ~acc;
         if (n % 8 == 7) begin
            acc = '1;
            lat = '0;
            sel = {rng[15:0], xs(rng)};
         end
         @(negedge clk);
         acc = '0;
         chk("pulse_end", {dr, df, cr, cf}, 20'h0);
      end
      end_sim();
   end
   // watchdog well past the expected run length
   initial begin
      #(300 * 6 * 50);
      miscompares++;
      end_sim();
   end
endmodule : test_drive_order_trigger_logic
